//--- src/slkc_cfg.svh
// Constants of the switch lock controller: port and queue sizes, field positions,
// reset values and timing counts.
// Assumes inclusion by bare name from design files only.
`ifndef SLKC_CFG_SVH
`define SLKC_CFG_SVH

// ***************************************************************
// Structure
// ***************************************************************
`define SLKC_NPORTS 7
`define SLKC_UP_PORT 3'h0
`define SLKC_FIFO_DEPTH 4

// ***************************************************************
// Switch status register fields
// ***************************************************************
`define SLKC_STS_LOCK_BIT 0
`define SLKC_STS_PLOCK_BIT 1
`define SLKC_STS_RESET 8'h00

// ***************************************************************
// Timing
// ***************************************************************
`define SLKC_CLK_MHZ 100
`define SLKC_HOLD_TIMEOUT_US 100
`define SLKC_HOLD_TIMEOUT_CYC (`SLKC_HOLD_TIMEOUT_US * `SLKC_CLK_MHZ)

`endif

//--- src/slkc_ctrl.sv
// Lock tracking and blocking for a multi-port switch: upstream posted
// and lock-class queue, lock completion ordering, per-port blocking.
// Assumes port 0 is upstream; non-posted requests and completions
// travel on separate queues and so may pass this one freely.
//
// How it works
// - Only one lock sequence at a time.
// - Locked read starts, locked data completion establishes.
// - Locked read locks target port, blocks others.
// - Locked read follows queued posted requests.
// - Port-only lock blocks no other destination.
// - Locked data completion locks whole switch.
// - Locked data completion waits for port's posted.
// - Failed lock keeps state until Unlock.
// - Status stays readable while switch locked.
// - Repeat locked reads leave lock state alone.
// - Writes to locked device pass, no change.
// - Self-generated messages bypass the lock blocking.
// - Unlock clears lock, goes to locked port.
// - Unlock releases only after posted ahead drain.
// - Blocked packets are held, maybe timed out.
// - Status register flag shows switch lock.
`timescale 1ns/1ps
`default_nettype none
`include "slkc_cfg.svh"
module slkc_ctrl
   import slkc_pkg::*;
#(
   parameter int NPORTS = `SLKC_NPORTS,
   parameter int FIFO_DEPTH = `SLKC_FIFO_DEPTH,
   parameter int HOLD_TIMEOUT_CYC = `SLKC_HOLD_TIMEOUT_CYC
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // Upstream ingress: posted and lock-class TLPs from the root
   input wire logic us_valid_in,
   input wire slkc_tlp_t us_tlp_in,
   output logic us_ready_out,
   // Egress towards downstream ports
   output logic dn_valid_out,
   output slkc_tlp_t dn_tlp_out,
   input wire logic dn_ready_in,
   // Lock completions from downstream ports
   input wire logic dn_cpl_valid_in,
   input wire slkc_tlp_t dn_cpl_in,
   output logic dn_cpl_ready_out,
   input wire logic [NPORTS-1:0] dn_posted_pending_in,
   // Lock completions towards the root
   output logic us_cpl_valid_out,
   output slkc_tlp_t us_cpl_out,
   input wire logic us_cpl_ready_in,
   // Downstream candidate blocking
   input wire slkc_req_t [NPORTS-1:0] req_in,
   output logic [NPORTS-1:0] hold_out,
   output logic [NPORTS-1:0] discard_out,
   // Management view
   output logic [7:0] switch_status_register_out,
   output slkc_port_t lock_port_out
);
   // ***************************************************************
   // Upstream queue
   // ***************************************************************
   slkc_state_t state;
   slkc_port_t lock_port;
   slkc_tlp_t head;
   logic head_valid;
   logic pop;
   logic out_valid;
   slkc_tlp_t out_tlp;
   logic out_fire;
   logic cpl_hold;
   slkc_tlp_t cpl_reg;
   logic cpl_wait;
   logic cpl_fire;
   logic [7:0] next_status;

   // One in-order queue keeps lock reads and Unlock behind posted
   slkc_fifo #(
      .WIDTH($bits(slkc_tlp_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .in_valid_in(us_valid_in),
      .in_data_in(us_tlp_in),
      .in_ready_out(us_ready_out),
      .out_valid_out(head_valid),
      .out_data_out(head),
      .out_ready_in(pop)
   );

   // ***************************************************************
   // Egress register
   // ***************************************************************
   assign pop = head_valid && (!out_valid || dn_ready_in);
   assign out_fire = out_valid && dn_ready_in;
   assign dn_valid_out = out_valid;
   assign dn_tlp_out = out_tlp;

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         out_valid <= 1'b0;
         out_tlp <= '0;
      end else if (pop) begin
         out_valid <= 1'b1;
         out_tlp <= head;
         if (head.kind == SLKC_UNLOCK && state != SLKC_IDLE) begin
            out_tlp.dest <= lock_port;
         end
      end else if (out_fire) begin
         out_valid <= 1'b0;
      end
   end

   // ***************************************************************
   // Lock completion path
   // ***************************************************************
   // Only a locked data completion waits on the port's posted traffic
   assign cpl_wait = (cpl_reg.kind == SLKC_CPLDLK) &&
                     dn_posted_pending_in[cpl_reg.src];
   assign us_cpl_valid_out = cpl_hold && !cpl_wait;
   assign us_cpl_out = cpl_reg;
   assign dn_cpl_ready_out = !cpl_hold;
   assign cpl_fire = us_cpl_valid_out && us_cpl_ready_in;

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         cpl_hold <= 1'b0;
         cpl_reg <= '0;
      end else if (dn_cpl_valid_in && !cpl_hold) begin
         cpl_hold <= 1'b1;
         cpl_reg <= dn_cpl_in;
      end else if (cpl_fire) begin
         cpl_hold <= 1'b0;
      end
   end

   // ***************************************************************
   // Lock state
   // ***************************************************************
   // Lock begins when the read leaves the queue, ends on delivery of
   // the Unlock, so every posted request ahead has gone out first
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         state <= SLKC_IDLE;
         lock_port <= `SLKC_UP_PORT;
      end else begin
         case (state)
            SLKC_IDLE: begin
               if (pop && head.kind == SLKC_MRDLK) begin
                  state <= SLKC_PORT_LOCKED;
                  lock_port <= head.dest;
               end
            end
            SLKC_PORT_LOCKED: begin
               // A failed attempt leaves the port lock in place
               if (out_fire && out_tlp.kind == SLKC_UNLOCK) begin
                  state <= SLKC_IDLE;
               end else if (cpl_fire && cpl_reg.kind == SLKC_CPLDLK &&
                            cpl_reg.src == lock_port) begin
                  state <= SLKC_SW_LOCKED;
               end
            end
            SLKC_SW_LOCKED: begin
               // Reads, writes and completions leave it as is
               if (out_fire && out_tlp.kind == SLKC_UNLOCK) begin
                  state <= SLKC_IDLE;
               end
            end
            default: state <= SLKC_IDLE;
         endcase
      end
   end

   // ***************************************************************
   // Downstream blocking
   // ***************************************************************
   // Root traffic is never blocked by the lock
   assign hold_out[0] = 1'b0;
   assign discard_out[0] = 1'b0;

   for (genvar p = 1; p < NPORTS; p++) begin : g_gate
      slkc_gate #(
         .PORT_ID(slkc_port_t'(p)),
         .TIMEOUT_CYC(HOLD_TIMEOUT_CYC)
      ) u_gate (
         .ref_clk_in(ref_clk_in),
         .rst_n_in(rst_n_in),
         .req_in(req_in[p]),
         .state_in(state),
         .lock_port_in(lock_port),
         .hold_out(hold_out[p]),
         .discard_out(discard_out[p])
      );
   end

   // ***************************************************************
   // Management status
   // ***************************************************************
   // Plain flops, never stalled by the lock, so the sideband
   // management reader always gets an answer
   always_comb begin
      next_status = `SLKC_STS_RESET;
      next_status[`SLKC_STS_LOCK_BIT] = (state == SLKC_SW_LOCKED);
      next_status[`SLKC_STS_PLOCK_BIT] = (state != SLKC_IDLE);
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         switch_status_register_out <= `SLKC_STS_RESET;
         lock_port_out <= `SLKC_UP_PORT;
      end else begin
         switch_status_register_out <= next_status;
         lock_port_out <= lock_port;
      end
   end

   // ***************************************************************
   // Assertions
   // ***************************************************************
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   sequence lock_read_taken;
      state == SLKC_IDLE && pop && head.kind == SLKC_MRDLK;
   endsequence

   sequence lock_data_done;
      state == SLKC_PORT_LOCKED && cpl_fire && cpl_reg.kind == SLKC_CPLDLK &&
      cpl_reg.src == lock_port && !(out_fire && out_tlp.kind == SLKC_UNLOCK);
   endsequence

   sequence unlock_delivered;
      out_fire && out_tlp.kind == SLKC_UNLOCK;
   endsequence

   single_lock_a: assert property (
      (state != SLKC_IDLE && $past(state) != SLKC_IDLE) |-> $stable(lock_port))
      else $error("lock port changed during a lock");

   port_lock_a: assert property (
      lock_read_taken |=> state == SLKC_PORT_LOCKED && lock_port == $past(head.dest))
      else $error("locked read did not lock its port");

   switch_lock_a: assert property (
      lock_data_done |=> state == SLKC_SW_LOCKED ##1 switch_status_register_out[0])
      else $error("locked data completion did not lock the switch");

   cpl_order_a: assert property (
      us_cpl_valid_out && us_cpl_out.kind == SLKC_CPLDLK |->
      !dn_posted_pending_in[us_cpl_out.src])
      else $error("locked completion passed posted traffic");

   fail_keep_a: assert property (
      state == SLKC_PORT_LOCKED && cpl_fire && cpl_reg.kind == SLKC_CPLLK &&
      !out_fire |=> state == SLKC_PORT_LOCKED)
      else $error("failed lock released port lock early");

   relock_keep_a: assert property (
      state == SLKC_SW_LOCKED && !out_fire |=> state == SLKC_SW_LOCKED)
      else $error("switch lock changed without unlock");

   unlock_clear_a: assert property (
      unlock_delivered |=> state == SLKC_IDLE ##1 !switch_status_register_out[1])
      else $error("unlock did not clear the lock");

   unlock_dest_a: assert property (
      pop && head.kind == SLKC_UNLOCK && state != SLKC_IDLE |=>
      dn_tlp_out.dest == $past(lock_port))
      else $error("unlock not sent to the locked port");

   unlock_wait_a: assert property (
      $rose(state == SLKC_IDLE) |-> $past(out_fire && out_tlp.kind == SLKC_UNLOCK))
      else $error("lock released before unlock delivery");

   other_port_a: assert property (
      state == SLKC_PORT_LOCKED && req_in[1].valid && req_in[1].dest != lock_port
      |-> !hold_out[1])
      else $error("port lock blocked an unrelated destination");

   status_flag_a: assert property (
      ##1 switch_status_register_out[0] == ($past(state) == SLKC_SW_LOCKED))
      else $error("status flag does not follow switch lock");

   reset_clear_a: assert property (
      $rose(rst_n_in) |-> state == SLKC_IDLE && hold_out == '0)
      else $error("not unlocked after reset");

   lock_cause_a: assert property (
      $rose(state == SLKC_SW_LOCKED) |->
      $past(cpl_fire && cpl_reg.kind == SLKC_CPLDLK))
      else $error("switch locked without a locked data completion");

   port_block_a: assert property (
      state == SLKC_PORT_LOCKED && req_in[3].valid && !req_in[3].self_gen &&
      req_in[3].dest == lock_port |-> hold_out[3])
      else $error("traffic to the locked port was not held");

   read_out_a: assert property (
      lock_read_taken |=> dn_valid_out && dn_tlp_out.kind == SLKC_MRDLK)
      else $error("locked read did not go out next");

   switch_block_a: assert property (
      state == SLKC_SW_LOCKED && lock_port != 3'h3 && req_in[3].valid &&
      !req_in[3].self_gen && req_in[3].dest == `SLKC_UP_PORT |-> hold_out[3])
      else $error("switch lock let traffic reach the upstream port");

   cpl_lock_keep_a: assert property (
      state == SLKC_SW_LOCKED && cpl_fire && cpl_reg.kind == SLKC_CPLLK &&
      !out_fire |=> state == SLKC_SW_LOCKED)
      else $error("failed completion unlocked the switch");

   write_keep_a: assert property (
      state == SLKC_SW_LOCKED && out_fire && out_tlp.kind == SLKC_MWR |=>
      state == SLKC_SW_LOCKED)
      else $error("forwarded write changed the switch lock");

   self_pass_a: assert property (
      req_in[3].valid && req_in[3].self_gen |-> !hold_out[3])
      else $error("self-generated message held by the lock");

   unlock_free_a: assert property (
      state == SLKC_IDLE |-> hold_out == '0)
      else $error("traffic held while unlocked");

   discard_held_a: assert property (
      discard_out[4] |-> $past(hold_out[4]))
      else $error("discard without a preceding hold");

   reset_quiet_a: assert property (
      $rose(rst_n_in) |-> !dn_valid_out && !us_cpl_valid_out && dn_cpl_ready_out &&
      us_ready_out && switch_status_register_out == `SLKC_STS_RESET)
      else $error("paths not idle after reset");
endmodule // slkc_ctrl
`default_nettype wire

//--- src/slkc_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module slkc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // Fill side
   input wire logic in_valid_in,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic in_ready_out,
   // Drain side
   output logic out_valid_out,
   output logic [WIDTH-1:0] out_data_out,
   input wire logic out_ready_in
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   assign in_ready_out = (count != (AW+1)'(DEPTH));
   assign out_valid_out = (count != '0);
   assign out_data_out = mem[rd_ptr];
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;

   always_ff @(posedge ref_clk_in) begin
      if (push) begin
         mem[wr_ptr] <= in_data_in;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // slkc_fifo
`default_nettype wire

//--- src/slkc_gate.sv
// Per-source blocking gate: decides whether a downstream port's
// candidate TLP must be held back by the lock, and times long holds.
// Assumes lock state and port come from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "slkc_cfg.svh"
module slkc_gate
   import slkc_pkg::*;
#(
   parameter slkc_port_t PORT_ID = 3'h1,
   parameter int TIMEOUT_CYC = `SLKC_HOLD_TIMEOUT_CYC
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // Candidate and lock view
   input wire slkc_req_t req_in,
   input wire slkc_state_t state_in,
   input wire slkc_port_t lock_port_in,
   // Decision
   output logic hold_out,
   output logic discard_out
);
   localparam int CW = $clog2(TIMEOUT_CYC + 1);

   logic [CW-1:0] hold_cnt;
   logic to_lock_port;
   logic to_up_port;

   assign to_lock_port = (req_in.dest == lock_port_in);
   assign to_up_port = (req_in.dest == `SLKC_UP_PORT);

   // Self-generated messages never wait on the lock
   always_comb begin
      hold_out = 1'b0;
      if (req_in.valid && !req_in.self_gen) begin
         case (state_in)
            SLKC_PORT_LOCKED: hold_out = to_lock_port;
            SLKC_SW_LOCKED: hold_out = (PORT_ID != lock_port_in) &&
                                       (to_lock_port || to_up_port);
            default: hold_out = 1'b0;
         endcase
      end
   end

   // Held, not rejected; only a long hold is dropped
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         hold_cnt <= '0;
         discard_out <= 1'b0;
      end else if (!hold_out) begin
         hold_cnt <= '0;
         discard_out <= 1'b0;
      end else if (hold_cnt == CW'(TIMEOUT_CYC - 1)) begin
         hold_cnt <= '0;
         discard_out <= 1'b1;
      end else begin
         hold_cnt <= hold_cnt + 1'b1;
         discard_out <= 1'b0;
      end
   end
endmodule // slkc_gate
`default_nettype wire

//--- src/slkc_pkg.sv
// Types shared by the switch lock controller files.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package slkc_pkg;

   typedef logic [2:0] slkc_port_t;

   typedef enum logic [3:0] {
      SLKC_MWR    = 4'h0,
      SLKC_MRD    = 4'h1,
      SLKC_MRDLK  = 4'h2,
      SLKC_CPL    = 4'h3,
      SLKC_CPLD   = 4'h4,
      SLKC_CPLLK  = 4'h5,
      SLKC_CPLDLK = 4'h6,
      SLKC_UNLOCK = 4'h7,
      SLKC_MSG    = 4'h8,
      SLKC_CFG    = 4'h9
   } slkc_kind_t;

   typedef enum logic [1:0] {
      SLKC_IDLE        = 2'b00,
      SLKC_PORT_LOCKED = 2'b01,
      SLKC_SW_LOCKED   = 2'b10
   } slkc_state_t;

   typedef struct packed {
      slkc_kind_t kind;
      slkc_port_t dest;
      slkc_port_t src;
      logic [7:0] tag;
   } slkc_tlp_t;

   typedef struct packed {
      logic valid;
      logic self_gen;
      slkc_port_t dest;
   } slkc_req_t;

endpackage
`default_nettype wire

//--- tb/slkc_far_model.sv
// Far-side endpoint model: takes egress TLPs, answers locked reads.
// Assumes one clock; drives outputs 1 ns after the rising edge.
`timescale 1ns/1ps
`default_nettype none
module slkc_far_model
   import slkc_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // Egress side
   input wire logic dn_valid_in,
   input wire slkc_tlp_t dn_tlp_in,
   output logic dn_ready_out,
   // Completion side
   output logic cpl_valid_out,
   output slkc_tlp_t cpl_out,
   input wire logic cpl_ready_in,
   // Bench commands
   input wire logic stall_in,
   input wire logic cpl_hold_in,
   input wire logic fail_in
);
   logic tog;
   logic pend;
   logic hs;
   logic ch;
   slkc_tlp_t nxt;
   slkc_tlp_t got;
   initial begin
      dn_ready_out = 1'b0;
      cpl_valid_out = 1'b0;
      cpl_out = '0;
      tog = 1'b0;
      pend = 1'b0;
      nxt = '0;
   end
   always @(posedge ref_clk_in) begin
      hs = dn_valid_in && dn_ready_out;
      ch = cpl_valid_out && cpl_ready_in;
      // The word taken is the one standing at the edge; the next loads at once
      got = dn_tlp_in;
      #1;
      tog = !tog;
      // Slow taker: at most every other cycle
      dn_ready_out = rst_n_in && !stall_in && tog;
      if (!rst_n_in) begin
         pend = 1'b0;
         cpl_valid_out = 1'b0;
      end else begin
         // Only lock completions answer a locked read
         if (hs && got.kind == SLKC_MRDLK) begin
            pend = 1'b1;
            nxt = {(fail_in ? SLKC_CPLLK : SLKC_CPLDLK), 3'h0, got.dest, got.tag};
         end
         if (ch) begin
            cpl_valid_out = 1'b0;
            // Released: no stale completion left on the lines
            cpl_out = ~cpl_out;
         end
         if (pend && !cpl_valid_out && !cpl_hold_in) begin
            cpl_valid_out = 1'b1;
            cpl_out = nxt;
            pend = 1'b0;
         end
      end
   end
endmodule // slkc_far_model
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench of the switch lock controller.
// Assumes the far model stands on the egress and completion paths.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import slkc_pkg::*;
   logic ref_clk_in, rst_n_in, us_valid, us_ready, dn_valid, dn_ready;
   logic dc_valid, dc_ready, uc_valid, uc_ready, stall, cpl_hold, fail;
   slkc_tlp_t us_tlp, dn_tlp, dc_tlp, uc_tlp;
   logic [6:0] pending, hold, discard;
   slkc_req_t [6:0] req;
   logic [7:0] sts;
   slkc_port_t lport;
   slkc_tlp_t q[$];
   int fails = 0, n_checks = 0, cyc = 0, seed = 32'h3f45, i, first;
   slkc_ctrl #(.HOLD_TIMEOUT_CYC(16)) slkc_ctrl_i (.ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in), .us_valid_in(us_valid), .us_tlp_in(us_tlp),
      .us_ready_out(us_ready), .dn_valid_out(dn_valid), .dn_tlp_out(dn_tlp),
      .dn_ready_in(dn_ready), .dn_cpl_valid_in(dc_valid), .dn_cpl_in(dc_tlp),
      .dn_cpl_ready_out(dc_ready), .dn_posted_pending_in(pending),
      .us_cpl_valid_out(uc_valid), .us_cpl_out(uc_tlp), .us_cpl_ready_in(uc_ready),
      .req_in(req), .hold_out(hold), .discard_out(discard),
      .switch_status_register_out(sts), .lock_port_out(lport));
   slkc_far_model slkc_far_model_i (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
      .dn_valid_in(dn_valid), .dn_tlp_in(dn_tlp), .dn_ready_out(dn_ready),
      .cpl_valid_out(dc_valid), .cpl_out(dc_tlp), .cpl_ready_in(dc_ready),
      .stall_in(stall), .cpl_hold_in(cpl_hold), .fail_in(fail));
   // ***************************************************************
   // Clock, watchdog, egress scoreboard
   // ***************************************************************
   initial begin
      ref_clk_in = 1'b0;
      forever #5 ref_clk_in = !ref_clk_in;
   end
   always @(posedge ref_clk_in) begin
      cyc++;
      if (cyc == 5000) begin
         fails++;
         final_report();
      end
   end
   always @(posedge ref_clk_in) begin
      if (rst_n_in && dn_valid && dn_ready) begin
         if (q.size() == 0) check("egress_extra", dn_tlp, '1);
         else check("egress", dn_tlp, q.pop_front());
      end
   end
   // ***************************************************************
   // Tasks
   // ***************************************************************
   task automatic check(input string nm, input logic [17:0] seen, input logic [17:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("FAIL %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tick();
      @(posedge ref_clk_in);
      #1;
   endtask
   task automatic push(input slkc_kind_t k, input slkc_port_t d, input logic [7:0] t,
                       input slkc_port_t ed);
      int n;
      // One edge with valid low between two calls
      tick();
      us_tlp = {k, d, 3'h0, t};
      us_valid = 1'b1;
      q.push_back({k, ed, 3'h0, t});
      for (n = 0; n < 100; n++) begin
         @(posedge ref_clk_in);
         if (us_ready) break;
      end
      #1 us_valid = 1'b0;
   endtask
   task automatic drain();
      for (i = 0; i < 100 && (q.size() != 0 || dn_valid !== 1'b0); i++) tick();
      check("drained", {17'h00000, q.size() == 0}, 18'h00001);
      repeat (3) tick();
   endtask
   task automatic cpl_take(input slkc_kind_t k, input slkc_port_t p, input logic [7:0] t);
      for (i = 0; i < 50 && uc_valid !== 1'b1; i++) tick();
      check("cpl_valid", {17'h00000, uc_valid}, 18'h00001);
      check("cpl", uc_tlp, {k, 3'h0, p, t});
      uc_ready = 1'b1;
      tick();
      uc_ready = 1'b0;
      repeat (3) tick();
   endtask
   task automatic hchk(input int s, input logic sg, input slkc_port_t d, input logic e);
      slkc_req_t [6:0] r;
      r = '0;
      r[s] = '{1'b1, sg, d};
      req = r;
      #2 check("hold", {11'h000, hold}, {11'h000, 7'(e) << s});
      #2 req = '0;
      tick();
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // ***************************************************************
   // Main sequence
   // ***************************************************************
   initial begin
      rst_n_in = 1'b0; us_valid = 1'b0; us_tlp = '0; uc_ready = 1'b0; pending = '0;
      req = '0; stall = 1'b0; cpl_hold = 1'b0; fail = 1'b0;
      repeat (10) @(posedge ref_clk_in);
      #1 rst_n_in = 1'b1;
      check("sts", sts, 8'h00);
      check("us_ready", us_ready, 1'b1);
      check("dc_ready", dc_ready, 1'b1);
      hchk(3, 1'b0, 3'h2, 1'b0);
      $display("test reset done");
      // Fill the queue while the far side stalls
      stall = 1'b1;
      repeat (5) begin
         first = $random(seed);
         push(SLKC_MWR, 3'(first[2:0] % 6 + 1), first[15:8], 3'(first[2:0] % 6 + 1));
      end
      repeat (2) tick();
      check("full", us_ready, 1'b0);
      stall = 1'b0;
      drain();
      $display("test fill done");
      // Port lock, completion waits behind posted traffic
      cpl_hold = 1'b1;
      pending = 7'h04;
      push(SLKC_MWR, 3'h2, 8'h10, 3'h2);
      push(SLKC_MRDLK, 3'h2, 8'h11, 3'h2);
      drain();
      check("sts", sts, 8'h02);
      check("lport", lport, 3'h2);
      hchk(3, 1'b0, 3'h2, 1'b1);
      hchk(3, 1'b0, 3'h0, 1'b0);
      hchk(4, 1'b0, 3'h3, 1'b0);
      hchk(1, 1'b0, 3'h3, 1'b0);
      hchk(3, 1'b1, 3'h2, 1'b0);
      cpl_hold = 1'b0;
      repeat (6) tick();
      check("cpl_wait", uc_valid, 1'b0);
      pending = '0;
      cpl_take(SLKC_CPLDLK, 3'h2, 8'h11);
      check("sts", sts, 8'h03);
      hchk(3, 1'b0, 3'h0, 1'b1);
      hchk(5, 1'b0, 3'h2, 1'b1);
      hchk(2, 1'b0, 3'h0, 1'b0);
      hchk(3, 1'b0, 3'h4, 1'b0);
      hchk(2, 1'b1, 3'h0, 1'b0);
      $display("test lock done");
      // Traffic inside the lock keeps the state
      fail = 1'b1;
      push(SLKC_MRDLK, 3'h2, 8'h12, 3'h2);
      drain();
      cpl_take(SLKC_CPLLK, 3'h2, 8'h12);
      fail = 1'b0;
      push(SLKC_MWR, 3'h2, 8'h13, 3'h2);
      drain();
      check("sts", sts, 8'h03);
      // Long hold ends in a discard, not sooner
      req[4] = '{1'b1, 1'b0, 3'h0};
      first = -1;
      for (i = 0; i < 30 && first < 0; i++) begin
         tick();
         check("held", hold[4], 1'b1);
         if (discard[4] === 1'b1) first = i;
      end
      req = '0;
      check("discard", first == 15, 1'b1);
      $display("test hold done");
      // Unlock goes to the locked port behind posted writes
      push(SLKC_MWR, 3'h2, 8'h14, 3'h2);
      push(SLKC_UNLOCK, 3'h5, 8'h15, 3'h2);
      drain();
      check("sts", sts, 8'h00);
      hchk(3, 1'b0, 3'h0, 1'b0);
      hchk(3, 1'b0, 3'h2, 1'b0);
      // Failed lock keeps the port lock until unlock
      fail = 1'b1;
      push(SLKC_MRDLK, 3'h4, 8'h16, 3'h4);
      drain();
      cpl_take(SLKC_CPLLK, 3'h4, 8'h16);
      check("sts", sts, 8'h02);
      check("lport", lport, 3'h4);
      fail = 1'b0;
      push(SLKC_UNLOCK, 3'h4, 8'h17, 3'h4);
      drain();
      check("sts", sts, 8'h00);
      $display("test unlock done");
      final_report();
   end
endmodule // tb_top
`default_nettype wire
